// [rtl/shf_link_tx.sv]
// fec sync header framer for a 64b/66b transmit lane
// ---------------------------------------------------------------
// Summary of operation
// - fec content in the sync header stream when mode select is 2
// - 26-bit parity over each multiblock, sent in the next one
// - stream bits 0..21, 23, 24..26 carry parity 25..4, 3, 2..0
// - stream bits 27..31 always carry 00001 end marker
// - stream bit 22 is 1 only in last multiblock of extended multiblock
// - parity uses generator x26+x21+x17+x9+x4+1
// - parity register cleared per multiblock, data bits only
// - no initial lane alignment sequence is sent
// - software sets serializer pre-emphasis; higher is stronger
// - enable low resets link, powers down serializer, gates clocks
// - header 01 sends 1, 10 sends 0; 32 blocks give 32 bits
// - sysref resets the lemc to a deterministic phase
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "shf_defines.svh"
module shf_link_tx #(
  parameter int EMB_MBS = 4     // multiblocks per extended multiblock
) (
  input  wire logic             clk,         // system clock, 20 MHz
  input  wire logic             resetn,      // async reset, active low
  input  wire logic             psel,        // apb select
  input  wire logic             penable,     // apb access phase
  input  wire logic             pwrite,      // apb direction
  input  wire logic [11:0]      paddr,       // apb byte address
  input  wire logic [31:0]      pwdata,      // apb write data
  output logic      [31:0]      prdata,      // apb read data
  output logic                  pready,      // apb ready
  output logic                  pslverr,     // apb error
  input  wire logic             sysref,      // lemc phase reset pulse
  input  wire shf_pkg::shf_blk_t blk_in,     // scrambled block in
  output var shf_pkg::shf_tx_t  tx_q,        // coded block out
  output logic                  ser_pd_q,    // serializer power down
  output logic                  clk_gate_q,  // link clock gate enable
  output logic      [3:0]       emph_out_q,  // pre-emphasis to driver
  output logic                  lemc_q       // lemc edge pulse
);
  localparam int EMBW = (EMB_MBS > 1) ? $clog2(EMB_MBS) : 1;

  logic        enable;
  logic [1:0]  mode;
  logic [3:0]  emph;
  logic [25:0] par_run;
  logic [25:0] par_hold_q;
  logic [25:0] par_hold_d;
  logic [31:0] shs_q;
  logic [31:0] shs_d;
  logic [4:0]  blk_q;
  logic [EMBW-1:0] mb_q;
  logic        first_q;
  logic        busy;
  logic        fec_on;
  logic        mb_start;
  logic        mb_last;
  logic        emb_last;
  logic        hdr_bit;
  logic        step;
  logic [25:0] par_sel;
  logic        lemc_hit;

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  shf_apb_regs u_regs (
    .clk      (clk),
    .resetn   (resetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .busy     (busy),
    .parity   (par_hold_q),
    .enable_q (enable),
    .mode_q   (mode),
    .emph_q   (emph)
  );

  // ---------------------------------------------------------------
  // multiblock position
  // ---------------------------------------------------------------
  assign busy     = enable;
  assign step     = enable & blk_in.valid;
  assign mb_start = step & (blk_q == 5'h00);
  assign mb_last  = step & (blk_q == 5'(`SHF_MB_BLOCKS - 1));
  assign emb_last = mb_q == EMBW'(EMB_MBS - 1);
  assign fec_on   = mode == `SHF_MODE_FEC;
  assign lemc_hit = mb_last & emb_last;

  // parity divider, cleared at every multiblock start
  shf_fec_lfsr #(
    .W (`SHF_BLK_BITS)
  ) u_fec (
    .clk     (clk),
    .resetn  (resetn),
    .clr     (mb_start),
    .step    (step),
    .data    (blk_in.data),
    .state_q (par_run)
  );

  // ---------------------------------------------------------------
  // sync header stream word for the multiblock about to start
  // ---------------------------------------------------------------
  // parity comes from the previous multiblock; the first one has none
  // the divider still holds the finished word of the last multiblock here
  assign par_sel = (fec_on && !first_q) ? par_run : 26'h0000000;
  always_comb begin
    shs_d = 32'h0;
    // stream bit 0 goes first and carries the parity msb
    for (int i = 0; i < 22; i++) begin
      shs_d[i] = par_sel[25 - i];
    end
    shs_d[`SHF_PAR3_BIT] = par_sel[3];
    for (int i = 0; i < 3; i++) begin
      shs_d[24 + i] = par_sel[2 - i];
    end
    shs_d[`SHF_EOEMB_BIT] = (mb_q == EMBW'(EMB_MBS - 1));
    shs_d[31:27] = `SHF_PILOT;
  end

  // stream bit 0 travels first; bit index equals block index
  assign hdr_bit = (blk_q == 5'h00) ? shs_d[0] : shs_q[blk_q];
  assign par_hold_d = (mb_start && !first_q) ? par_run : par_hold_q;

  // the finished parity ends in the lfsr one edge after the last block
  // so it is caught from the running state on the following start
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blk_q      <= 5'h00;
      mb_q       <= '0;
      first_q    <= 1'b1;
      shs_q      <= 32'h0;
      par_hold_q <= 26'h0000000;
    end else if (!enable) begin
      blk_q      <= 5'h00;
      mb_q       <= '0;
      first_q    <= 1'b1;
      shs_q      <= 32'h0;
      par_hold_q <= 26'h0000000;
    end else begin
      if (sysref) begin
        blk_q <= 5'h00;
        mb_q  <= '0;
      end else if (step) begin
        blk_q <= blk_q + 5'h01;
        if (mb_last) begin
          mb_q    <= emb_last ? '0 : mb_q + EMBW'(1);
          first_q <= 1'b0;
        end
      end
      if (mb_start) begin
        shs_q <= shs_d;
      end
      par_hold_q <= par_hold_d;
    end
  end

  // ---------------------------------------------------------------
  // coded output, power and clock gating
  // ---------------------------------------------------------------
  // no alignment sequence: blocks flow as soon as the link is enabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_q       <= '0;
      ser_pd_q   <= 1'b1;
      clk_gate_q <= 1'b0;
      emph_out_q <= `SHF_EMPH_RST;
      lemc_q     <= 1'b0;
    end else begin
      tx_q.valid <= step;
      tx_q.hdr   <= hdr_bit ? `SHF_HDR_ONE : `SHF_HDR_ZERO;
      tx_q.data  <= step ? blk_in.data : 64'h0;
      ser_pd_q   <= ~enable;
      clk_gate_q <= enable;
      emph_out_q <= emph;
      lemc_q     <= lemc_hit;
    end
  end
endmodule : shf_link_tx
`default_nettype wire

// [rtl/shf_defines.svh]
// constants for the sync header fec link layer
`ifndef SHF_DEFINES_SVH
`define SHF_DEFINES_SVH
// ---------------------------------------------------------------
// apb register map
// ---------------------------------------------------------------
`define SHF_OFS_CTRL      12'h000
`define SHF_OFS_EMPH      12'h004
`define SHF_OFS_STATUS    12'h008
`define SHF_OFS_PARITY    12'h00c
// ---------------------------------------------------------------
// field positions and values
// ---------------------------------------------------------------
`define SHF_CTRL_EN_BIT   0
`define SHF_CTRL_MODE_LO  4
`define SHF_CTRL_MODE_HI  5
`define SHF_MODE_FEC      2'h2
`define SHF_MODE_CRC      2'h0
`define SHF_EMPH_RST      4'h0
// ---------------------------------------------------------------
// sync header stream layout
// ---------------------------------------------------------------
`define SHF_POLY          26'h0220211
`define SHF_EOEMB_BIT     22
`define SHF_PAR3_BIT      23
`define SHF_PILOT         5'h10 // stream bits 31..27: only bit 31, sent last, is high
`define SHF_HDR_ONE       2'h1
`define SHF_HDR_ZERO      2'h2
`define SHF_MB_BLOCKS     32
`define SHF_BLK_BITS      64
`endif

// [rtl/shf_pkg.sv]
// types for the sync header fec link layer
package shf_pkg;
  // one scrambled 64-bit block with its valid flag
  typedef struct packed {
    logic        valid;
    logic [63:0] data;
  } shf_blk_t;
  // one coded 66-bit block out to the serializer
  typedef struct packed {
    logic        valid;
    logic [1:0]  hdr;
    logic [63:0] data;
  } shf_tx_t;
endpackage : shf_pkg

// [rtl/shf_fec_lfsr.sv]
// fec parity generator: 64 bits per cycle through the 26-bit divider
`timescale 1ns/1ps
`default_nettype none
`include "shf_defines.svh"
module shf_fec_lfsr #(
  parameter int W = 64
) (
  input  wire logic          clk,      // system clock
  input  wire logic          resetn,   // async reset, active low
  input  wire logic          clr,      // start of multiblock
  input  wire logic          step,     // a block is present
  input  wire logic [W-1:0]  data,     // scrambled block, msb first
  output logic      [25:0]   state_q   // running parity
);
  logic [25:0] seed;
  logic [25:0] nxt;

  // ---------------------------------------------------------------
  // serial divide unrolled over one block, msb first
  // ---------------------------------------------------------------
  assign seed = clr ? 26'h0000000 : state_q;
  always_comb begin
    logic fb;
    nxt = seed;
    fb  = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      fb  = nxt[25] ^ data[i];
      nxt = {nxt[24:0], 1'b0} ^ (fb ? `SHF_POLY : 26'h0000000);
    end
  end

  // clear and first block fold into one edge, so no bubble cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= 26'h0000000;
    end else if (step) begin
      state_q <= nxt;
    end else if (clr) begin
      state_q <= 26'h0000000;
    end
  end
endmodule : shf_fec_lfsr
`default_nettype wire

// [rtl/shf_apb_regs.sv]
// apb slave holding control, emphasis and status registers
`timescale 1ns/1ps
`default_nettype none
`include "shf_defines.svh"
module shf_apb_regs (
  input  wire logic        clk,        // system clock
  input  wire logic        resetn,     // async reset, active low
  input  wire logic        psel,       // apb select
  input  wire logic        penable,    // apb access phase
  input  wire logic        pwrite,     // apb direction
  input  wire logic [11:0] paddr,      // apb byte address
  input  wire logic [31:0] pwdata,     // apb write data
  output logic      [31:0] prdata,     // apb read data
  output logic             pready,     // apb ready
  output logic             pslverr,    // apb error
  input  wire logic        busy,       // link active
  input  wire logic [25:0] parity,     // last finished multiblock parity
  output logic             enable_q,   // link enable
  output logic      [1:0]  mode_q,     // sync header mode select
  output logic      [3:0]  emph_q      // pre-emphasis level
);
  logic        acc;
  logic        hit_ctrl;
  logic        hit_emph;
  logic        hit_stat;
  logic        hit_par;
  logic        mapped;
  logic [31:0] rd_mux;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign acc      = psel & penable;
  assign hit_ctrl = paddr == `SHF_OFS_CTRL;
  assign hit_emph = paddr == `SHF_OFS_EMPH;
  assign hit_stat = paddr == `SHF_OFS_STATUS;
  assign hit_par  = paddr == `SHF_OFS_PARITY;
  assign mapped   = hit_ctrl | hit_emph | hit_stat | hit_par;
  assign pready   = 1'b1;
  assign pslverr  = acc & ~mapped;
  assign rd_mux   = hit_ctrl ? {26'h0, mode_q, 3'h0, enable_q} :
                    hit_emph ? {28'h0, emph_q} :
                    hit_stat ? {31'h0, busy} :
                    hit_par  ? {6'h0, parity} : 32'h0;
  assign prdata   = acc ? rd_mux : 32'h0;

  // writes take effect in the access cycle, zero wait states
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enable_q <= 1'b0;
      mode_q   <= `SHF_MODE_CRC;
      emph_q   <= `SHF_EMPH_RST;
    end else if (acc && pwrite) begin
      if (hit_ctrl) begin
        enable_q <= pwdata[`SHF_CTRL_EN_BIT];
        mode_q   <= pwdata[`SHF_CTRL_MODE_HI:`SHF_CTRL_MODE_LO];
      end
      if (hit_emph) begin
        emph_q <= pwdata[3:0];
      end
    end
  end
endmodule : shf_apb_regs
`default_nettype wire

// [tb/shf_link_tx_props.sv]
// assertion checker for the fec sync header framer
`timescale 1ns/1ps
`default_nettype none
`include "shf_defines.svh"
module shf_link_tx_props #(
  parameter int EMB_MBS = 4  // multiblocks per extended one
) (
  input wire logic              clk,        // clock
  input wire logic              resetn,     // reset, low
  input wire logic              psel,       // apb
  input wire logic              penable,    // apb
  input wire logic              pwrite,     // apb
  input wire logic [11:0]       paddr,      // apb
  input wire logic [31:0]       pwdata,     // apb
  input wire logic [31:0]       prdata,     // apb
  input wire logic              pready,     // apb
  input wire logic              pslverr,    // apb
  input wire logic              sysref,     // lemc reset
  input wire shf_pkg::shf_blk_t blk_in,     // block in
  input wire shf_pkg::shf_tx_t  tx_q,       // block out
  input wire logic              ser_pd_q,   // power down
  input wire logic              clk_gate_q, // clock run
  input wire logic [3:0]        emph_out_q, // emphasis
  input wire logic              lemc_q      // lemc pulse
);
  // ---------------------------------------------------------------
  // helper state
  // ---------------------------------------------------------------
  logic [4:0] blk_q;
  logic [7:0] mb_q;
  logic       first_q;
  logic       fec_q;
  logic [3:0] emph_q;
  wire acc = psel && penable;
  wire wr_ctrl = acc && pwrite && paddr == `SHF_OFS_CTRL;
  wire wr_emph = acc && pwrite && paddr == `SHF_OFS_EMPH;
  wire par_pos = blk_q < 5'h16 || (blk_q > 5'h16 && blk_q < 5'h1b);
  wire last_mb = mb_q == 8'(EMB_MBS - 1);
  // block position; restarts while the link is down, as the framer does
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blk_q <= 5'h00;
      mb_q <= 8'h00;
      first_q <= 1'b1;
    end else if (ser_pd_q) begin
      blk_q <= 5'h00;
      mb_q <= 8'h00;
      first_q <= 1'b1;
    end else if (tx_q.valid) begin
      blk_q <= blk_q + 5'h01;
      if (blk_q == 5'h1f) begin
        first_q <= 1'b0;
        mb_q <= last_mb ? 8'h00 : mb_q + 8'h01;
      end
    end
  end
  // shadow of the written mode and emphasis
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fec_q <= 1'b0;
      emph_q <= 4'h0;
    end else begin
      if (wr_ctrl) fec_q <= pwdata[5:4] == `SHF_MODE_FEC;
      if (wr_emph) emph_q <= pwdata[3:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  AST_HDR: assert property (tx_q.valid |-> tx_q.hdr inside {2'h1, 2'h2})
    else $error("illegal sync header");
  AST_PILOT: assert property (tx_q.valid && blk_q > 5'h1a |->
    tx_q.hdr == ((blk_q == 5'h1f) ? 2'h1 : 2'h2)) else $error("end marker wrong");
  AST_EOEMB: assert property (tx_q.valid && blk_q == 5'h16 |->
    tx_q.hdr == (last_mb ? 2'h1 : 2'h2)) else $error("extended flag wrong");
  AST_FIRST: assert property (fec_q && first_q && tx_q.valid && par_pos |->
    tx_q.hdr == 2'h2) else $error("first parity not zero");
  AST_PASS: assert property (blk_in.valid && clk_gate_q |=>
    tx_q.valid && tx_q.data == $past(blk_in.data)) else $error("block lost");
  AST_OFF: assert property (ser_pd_q && $past(ser_pd_q) |-> !tx_q.valid)
    else $error("sent while disabled");
  AST_GATE: assert property (clk_gate_q == !ser_pd_q)
    else $error("gate and power down disagree");
  AST_EMPH: assert property (wr_emph |=> ##[0:1] emph_out_q == emph_q)
    else $error("emphasis not applied");
  AST_LEMC: assert property (tx_q.valid && blk_q == 5'h1f && last_mb |->
    ##[0:1] lemc_q ##1 !lemc_q) else $error("lemc pulse wrong");
  AST_APB: assert property (acc |-> pready && pslverr == (paddr > 12'h00c))
    else $error("apb answer wrong");
  COV_LEMC: cover property (lemc_q);
  COV_EMPH: cover property (wr_emph);
  COV_ERR: cover property (acc && pslverr);
endmodule : shf_link_tx_props
`default_nettype wire

// [tb/shf_rx_model.sv]
// receiver model: rebuilds the sync header stream and checks it
`timescale 1ns/1ps
`default_nettype none
module shf_rx_model #(
  parameter int EMB = 4                // multiblocks per extended multiblock
) (
  input  wire logic             clk,  // clock
  input  wire logic             clr,  // link down, restart
  input  wire logic             fec,  // fec content expected
  input  wire logic             lemc, // lemc edge, release reference
  input  wire shf_pkg::shf_tx_t rx,   // coded block in
  output logic [7:0]            mbs,  // multiblocks seen
  output logic [7:0]            bad,  // faults seen
  output logic                  rel   // elastic buffer released
);
  logic [25:0] s, prev, rp;
  logic [4:0]  k;
  logic [7:0]  mi;
  logic        b, algn, bufd;
  // serial divider over data only, msb first; parity checked a multiblock late
  always @(posedge clk) begin
    if (clr) begin
      s = '0;
      prev = '0;
      rp = '0;
      k = '0;
      mi = '0;
      mbs = '0;
      bad = '0;
      {algn, bufd, rel} = '0;
    end else begin
      if (rx.valid) begin
        b = rx.hdr == 2'h1;
        if (k == 0 && mi == 0 && algn) bufd = 1'b1;
        if (!(rx.hdr inside {2'h1, 2'h2})) bad = bad + 8'h01;
        if (k < 22) rp[25-k] = b;
        else if (k > 22 && k < 27) rp[26-k] = b;
        if (k == 22 && b !== (mi == EMB - 1)) bad = bad + 8'h01;
        if (k > 26 && b !== (k == 31)) bad = bad + 8'h01;
        // nonzero syndrome is a fault; burst location is not decoded here
        if (k == 26 && rp !== (fec ? prev : 26'h0)) bad = bad + 8'h01;
        for (int i = 63; i >= 0; i--)
          s = {s[24:0], 1'b0} ^ ((rx.data[i] ^ s[25]) ? 26'h0220211 : 26'h0);
        if (k == 31) begin
          // marker confirmed at two multiblock ends before trusting it
          if (mbs != 0 && bad == 0) algn = 1'b1;
          mi = (mi == EMB - 1) ? 8'h00 : mi + 8'h01;
          prev = s;
          s = '0;
          mbs = mbs + 8'h01;
        end
        k = k + 5'h01;
      end
      // rbd of zero: release on the lemc edge, clear of the delay spread
      if (lemc && bufd) rel = 1'b1;
    end
  end
endmodule : shf_rx_model
`default_nettype wire

// [tb/sync_header_fec_link_layer_test.sv]
// self-checking bench for the fec sync header framer
`timescale 1ns/1ps
`default_nettype none
`include "shf_defines.svh"
module sync_header_fec_link_layer_test;
  localparam int EMB = 2;
  logic clk, resetn, psel, penable, pwrite, sysref, fec, pready, pslverr, err;
  logic ser_pd_q, clk_gate_q, lemc_q, rel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] emph_out_q;
  logic [7:0] mbs, bad;
  shf_pkg::shf_blk_t blk_in;
  shf_pkg::shf_tx_t tx_q;
  int fail_count, n_tests, cyc, nlemc;
  shf_link_tx #(.EMB_MBS(EMB)) shf_link_tx_i (.clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sysref, .blk_in,
    .tx_q, .ser_pd_q, .clk_gate_q, .emph_out_q, .lemc_q);
  shf_rx_model #(.EMB(EMB)) shf_rx_model_i (.clk, .clr(ser_pd_q), .fec, .lemc(lemc_q),
    .rx(tx_q), .mbs, .bad, .rel);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // lemc pulses and hang guard
  always @(posedge clk) begin
    cyc++;
    if (lemc_q === 1'b1) nlemc++;
    if (cyc == 6000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic send(input int n, input logic gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      blk_in <= {1'b1, 32'(i) * 32'h9e3779b9, 32'(i) ^ 32'h5a5aa5a5};
      if (gap) begin
        @(posedge clk);
        blk_in.valid <= 1'b0;
      end
    end
    @(posedge clk);
    blk_in <= '0;
    repeat (3) @(posedge clk);
  endtask : send
  task automatic t_regs;
    chk(ser_pd_q, 1'b1);
    chk(clk_gate_q, 1'b0);
    apb(1'b0, `SHF_OFS_EMPH, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `SHF_OFS_EMPH, 32'h9);
    apb(1'b0, `SHF_OFS_EMPH, 32'h0);
    chk(rd, 32'h9);
    repeat (2) @(posedge clk);
    chk(emph_out_q, 4'h9);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask : t_regs
  task automatic t_fec;
    fec = 1'b1;
    apb(1'b1, `SHF_OFS_CTRL, 32'h20);
    apb(1'b1, `SHF_OFS_CTRL, 32'h21);
    apb(1'b0, `SHF_OFS_STATUS, 32'h0);
    chk(rd[0], 1'b1);
    repeat (2) @(posedge clk);
    chk(clk_gate_q, 1'b1);
    nlemc = 0;
    send(64 * EMB, 1'b0);
    chk(mbs, 8'(2 * EMB));
    chk(bad, 8'h0);
    chk(nlemc, 2);
    chk(rel, 1'b1);
  endtask : t_fec
  task automatic t_crc;
    apb(1'b1, `SHF_OFS_CTRL, 32'h20);
    sysref <= 1'b1;
    @(posedge clk);
    sysref <= 1'b0;
    fec = 1'b0;
    apb(1'b1, `SHF_OFS_CTRL, 32'h0);
    apb(1'b1, `SHF_OFS_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    send(64, 1'b1);
    chk({mbs, bad}, 16'h0200);
    chk(rel, 1'b0);
  endtask : t_crc
  task automatic t_off;
    apb(1'b1, `SHF_OFS_CTRL, 32'h20);
    fec = 1'b1;
    repeat (3) @(posedge clk);
    send(40, 1'b0);
    chk(mbs, 8'h0);
    apb(1'b1, `SHF_OFS_CTRL, 32'h21);
    repeat (2) @(posedge clk);
    send(64, 1'b0);
    chk({mbs, bad}, 16'h0200);
  endtask : t_off
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  initial begin
    {resetn, psel, penable, pwrite, sysref, fec} = '0;
    paddr = '0;
    pwdata = '0;
    blk_in = '0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_fec();
    t_crc();
    t_off();
    conclude();
  end
endmodule : sync_header_fec_link_layer_test
bind shf_link_tx shf_link_tx_props #(.EMB_MBS(EMB_MBS)) shf_link_tx_props_i (.clk, .resetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sysref,
  .blk_in, .tx_q, .ser_pd_q, .clk_gate_q, .emph_out_q, .lemc_q);
`default_nettype wire
